// ==== instr_class_exec.sv ====
`timescale 1ns/1ps
module instr_class_exec
	import instr_class_pkg::*;
(
	input  wire logic                 clock,              // System clock
	input  wire logic                 rst,                // Async reset
	input  wire logic                 op_valid,           // Operation present
	input  wire op_class_type         op_class,           // Operation class
	input  wire logic                 op_alt,             // Variant select
	input  wire logic                 op_long,            // Four byte form
	input  wire logic                 op_byte,            // Byte operands
	input  wire logic [WORD_W-1:0]    opnd_a,             // First operand
	input  wire logic [WORD_W-1:0]    opnd_b,             // Second operand
	input  wire logic [2*WORD_W-1:0]  muldiv_pair_in,     // Muldiv pair
	input  wire logic                 carry_in,           // Carry flag
	input  wire logic                 bit_in,             // Direct bit value
	input  wire logic                 nmi_level,          // Interrupt pin
	output logic                      done_r,             // Result strobe
	output logic [LEN_W-1:0]          length_r,           // Instr length
	output logic [WORD_W-1:0]         result_r,           // Main result
	output logic [WORD_W-1:0]         update_r,           // Register update
	output logic                      update_we_r,        // Update valid
	output logic [2*WORD_W-1:0]       muldiv_pair_r,      // Muldiv pair out
	output logic                      muldiv_we_r,        // Pair valid
	output logic                      carry_r,            // Carry result
	output logic                      zero_r,             // Zero result
	output logic                      div_err_r,          // Divide by zero
	output logic                      bit_out_r,          // Bit write value
	output logic                      bit_we_r,           // Bit write valid
	output logic                      branch_r,           // Branch taken
	output logic                      push_r,             // Push result_r
	output logic                      pop_r,              // Pop to register
	output logic                      call_r,             // Call issued
	output logic                      trap_r,             // Trap issued
	output logic [TRAP_W-1:0]         trap_num_r,         // Trap number
	output logic                      power_down_r,       // Power down level
	output logic                      reset_output_pin_r, // Init done pin
	output logic [SEG_W-1:0]          seg_r,              // Segment value
	output logic                      seg_we_r,           // Segment valid
	output logic [1:0]                seq_span_r,         // Override span
	output logic                      seq_reg_r           // Register ext
);

	// ================================================================
	// Helper functions
	// ================================================================

	// Encoded length of each class
	function automatic logic [LEN_W-1:0] instr_len(input op_class_type c,
		input logic lng);
		case (c)
			op_add, add_with_carry_op, op_sub, sub_with_carry_op,
			compare_decrement_op, compare_increment_op,
			move_sign_extend_op, move_zero_extend_op,
			segment_override_seq_op:
				instr_len = lng ? LEN_LONG : LEN_SHORT;
			bit_move_op, masked_field_op, branch_test_clear_op,
			branch_test_set_op, push_and_call_op, context_switch_op,
			power_down_op, end_of_init_op, segment_jump_op:
				instr_len = LEN_LONG;
			default:
				instr_len = LEN_SHORT;
		endcase
	endfunction : instr_len

	// Shift steps until bit 15 is one
	function automatic logic [WORD_W-1:0] lead_zeros(input logic [WORD_W-1:0] v);
		logic [WORD_W-1:0] n;
		logic              hit;
		n   = '0;
		hit = 1'b0;
		for (int i = SIGN_BIT; i >= 0; i--)
		begin
			if (v[i])
				hit = 1'b1;
			else if (!hit)
				n = n + STEP_ONE;
		end
		if (!hit)
			n = '0; // Zero word needs no shifting
		lead_zeros = n;
	endfunction : lead_zeros

	// ================================================================
	// Combinational execution
	// ================================================================
	logic [WORD_W-1:0]   result_nxt;  // Main result
	logic [WORD_W-1:0]   update_nxt;  // Second register value
	logic                update_we_nxt; // Second register write
	logic [2*WORD_W-1:0] md_nxt;      // Muldiv pair result
	logic                md_we_nxt;   // Muldiv pair write
	logic                carry_nxt;   // Carry flag
	logic                zero_nxt;    // Zero flag
	logic                div_err_nxt; // Divisor zero
	logic                bit_nxt;     // Bit value to store
	logic                bit_we_nxt;  // Bit store
	logic                branch_nxt;  // Branch decision
	logic [WORD_W:0]     sum;         // Adder with carry out
	logic [WORD_W-1:0]   cin_w;       // Carry as word
	logic [WORD_W-1:0]   step;        // Compare step size
	logic [WORD_W-1:0]   mask;        // Field mask placed
	logic [WORD_W-1:0]   fdata;       // Field data placed
	logic [2*WORD_W-1:0] dividend;    // Dividend selection
	logic [2*WORD_W-1:0] quot;        // Quotient wide
	logic [2*WORD_W-1:0] rem;         // Remainder wide

	always_comb
	begin
		result_nxt    = '0;
		update_nxt    = '0;
		update_we_nxt = 1'b0;
		md_nxt        = muldiv_pair_in;
		md_we_nxt     = 1'b0;
		carry_nxt     = 1'b0;
		div_err_nxt   = 1'b0;
		bit_nxt       = 1'b0;
		bit_we_nxt    = 1'b0;
		branch_nxt    = 1'b0;
		sum           = '0;
		quot          = '0;
		rem           = '0;
		cin_w         = {{(WORD_W-1){1'b0}}, carry_in};
		step          = op_alt ? STEP_TWO : STEP_ONE;
		mask          = op_alt ? {opnd_b[7:0], 8'h00} : {8'h00, opnd_b[7:0]};
		fdata         = op_alt ? {opnd_b[15:8], 8'h00} : {8'h00, opnd_b[15:8]};
		// Short form uses the low half only, sign or zero filled
		if (op_class == short_divide_op)
			dividend = (!op_alt && muldiv_pair_in[SIGN_BIT]) ?
				{16'hffff, muldiv_pair_in[WORD_W-1:0]} :
				{16'h0000, muldiv_pair_in[WORD_W-1:0]};
		else
			dividend = muldiv_pair_in;
		case (op_class)
			op_add, add_with_carry_op:
			begin
				// Carry enters as a third operand
				sum = {1'b0, opnd_a} + {1'b0, opnd_b} +
					((op_class == add_with_carry_op) ?
					{1'b0, cin_w} : 17'h00000);
				result_nxt = sum[WORD_W-1:0];
				carry_nxt  = op_byte ? (sum[8] ^ opnd_a[8] ^ opnd_b[8]) :
					sum[WORD_W];
			end
			op_sub, sub_with_carry_op:
			begin
				// Borrow joins the subtrahend
				sum = {1'b0, opnd_a} - {1'b0, opnd_b} -
					((op_class == sub_with_carry_op) ?
					{1'b0, cin_w} : 17'h00000);
				result_nxt = sum[WORD_W-1:0];
				carry_nxt  = sum[WORD_W];
			end
			multiply_op:
			begin
				// Signed when the variant bit is low
				md_we_nxt = 1'b1;
				if (op_alt)
					md_nxt = {16'h0000, opnd_a} * {16'h0000, opnd_b};
				else
					md_nxt = $signed({{16{opnd_a[SIGN_BIT]}}, opnd_a}) *
						$signed({{16{opnd_b[SIGN_BIT]}}, opnd_b});
				result_nxt = md_nxt[WORD_W-1:0];
			end
			short_divide_op, long_divide_op:
			begin
				// Quotient low, remainder high; zero divisor flagged
				md_we_nxt = 1'b1;
				if (opnd_b == '0)
				begin
					div_err_nxt = 1'b1;
					md_nxt      = '0;
				end
				else if (op_alt)
				begin
					quot   = dividend / {16'h0000, opnd_b};
					rem    = dividend % {16'h0000, opnd_b};
					md_nxt = {rem[WORD_W-1:0], quot[WORD_W-1:0]};
				end
				else
				begin
					quot   = 32'($signed(dividend) /
						$signed({{16{opnd_b[SIGN_BIT]}}, opnd_b}));
					rem    = 32'($signed(dividend) %
						$signed({{16{opnd_b[SIGN_BIT]}}, opnd_b}));
					md_nxt = {rem[WORD_W-1:0], quot[WORD_W-1:0]};
				end
				result_nxt = md_nxt[WORD_W-1:0];
			end
			compare_decrement_op, compare_increment_op:
			begin
				// Compare first, then step the register
				sum        = {1'b0, opnd_a} - {1'b0, opnd_b};
				result_nxt = sum[WORD_W-1:0];
				carry_nxt  = sum[WORD_W];
				update_we_nxt = 1'b1;
				if (op_class == compare_decrement_op)
					update_nxt = opnd_a - step;
				else
					update_nxt = opnd_a + step;
			end
			normalize_count_op:
				result_nxt = lead_zeros(opnd_a);
			arith_right_shift_op:
				result_nxt = WORD_W'($signed(opnd_a) >>> opnd_b[3:0]);
			op_logic_right_shift:
				result_nxt = opnd_a >> opnd_b[3:0];
			move_sign_extend_op:
				result_nxt = {{8{opnd_a[BYTE_SIGN]}}, opnd_a[7:0]};
			move_zero_extend_op:
				result_nxt = {8'h00, opnd_a[7:0]};
			bit_move_op:
			begin
				bit_nxt    = bit_in ^ op_alt;
				bit_we_nxt = 1'b1;
			end
			masked_field_op:
				result_nxt = (opnd_a & ~mask) | (fdata & mask);
			branch_test_clear_op:
			begin
				branch_nxt = bit_in;
				bit_nxt    = 1'b0;
				bit_we_nxt = bit_in;
			end
			branch_test_set_op:
			begin
				branch_nxt = !bit_in;
				bit_nxt    = 1'b1;
				bit_we_nxt = !bit_in;
			end
			push_and_call_op, segment_jump_op:
				result_nxt = opnd_b;
			context_switch_op:
			begin
				result_nxt    = opnd_a;
				update_nxt    = opnd_b;
				update_we_nxt = 1'b1;
			end
			default:
				result_nxt = '0;
		endcase
		zero_nxt = (result_nxt == '0);
	end

	// ================================================================
	// Registered results
	// ================================================================

	// Completion strobe and length
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			done_r   <= 1'b0;
			length_r <= '0;
		end
		else
		begin
			done_r <= op_valid;
			if (op_valid)
				length_r <= instr_len(op_class, op_long);
		end
	end

	// Data results and flags
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			result_r      <= '0;
			update_r      <= '0;
			update_we_r   <= 1'b0;
			muldiv_pair_r <= '0;
			muldiv_we_r   <= 1'b0;
			carry_r       <= 1'b0;
			zero_r        <= 1'b0;
			div_err_r     <= 1'b0;
			bit_out_r     <= 1'b0;
			bit_we_r      <= 1'b0;
			branch_r      <= 1'b0;
		end
		else
		begin
			update_we_r <= op_valid && update_we_nxt;
			muldiv_we_r <= op_valid && md_we_nxt;
			bit_we_r    <= op_valid && bit_we_nxt;
			branch_r    <= op_valid && branch_nxt;
			if (op_valid)
			begin
				result_r      <= result_nxt;
				update_r      <= update_nxt;
				muldiv_pair_r <= md_nxt;
				carry_r       <= carry_nxt;
				zero_r        <= zero_nxt;
				div_err_r     <= div_err_nxt;
				bit_out_r     <= bit_nxt;
			end
		end
	end

	// Stack and flow control strobes
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			push_r     <= 1'b0;
			pop_r      <= 1'b0;
			call_r     <= 1'b0;
			trap_r     <= 1'b0;
			trap_num_r <= '0;
		end
		else
		begin
			// Push carries result_r (opnd_b for push and call, opnd_a for context switch); call in the same cycle, trap on its own
			push_r <= op_valid && (op_class == push_and_call_op ||
				op_class == context_switch_op);
			call_r <= op_valid && op_class == push_and_call_op;
			pop_r  <= op_valid && op_class == return_and_pop_op;
			trap_r <= op_valid && op_class == op_trap;
			if (op_valid && op_class == op_trap)
				trap_num_r <= opnd_b[TRAP_W-1:0];
		end
	end

	// Power and initialization state
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			power_down_r       <= 1'b0;
			reset_output_pin_r <= 1'b0;
		end
		else
		begin
			// Request ignored unless the interrupt pin is low
			if (op_valid && op_class == power_down_op && !nmi_level)
				power_down_r <= 1'b1;
			if (op_valid && op_class == end_of_init_op)
				reset_output_pin_r <= 1'b1;
		end
	end

	// Segment jump and override sequence
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			seg_r      <= '0;
			seg_we_r   <= 1'b0;
			seq_span_r <= '0;
			seq_reg_r  <= 1'b0;
		end
		else
		begin
			seg_we_r <= op_valid && (op_class == segment_jump_op ||
				op_class == segment_override_seq_op);
			if (op_valid && op_class == segment_jump_op)
				seg_r <= opnd_a[SEG_W-1:0];
			else if (op_valid && op_class == segment_override_seq_op)
			begin
				seg_r      <= opnd_a[SEG_W-1:0];
				seq_span_r <= opnd_b[1:0] + SEQ_ONE;
				seq_reg_r  <= op_alt;
			end
		end
	end

endmodule : instr_class_exec

// ==== instr_class_pkg.sv ====
// ====================================================================
// Shared definitions for the instruction class executor
// ====================================================================
package instr_class_pkg;

	// ================================================================
	// Operation classes as presented by the fetch and decode front end
	// ================================================================
	typedef enum logic [4:0]
	{
		op_add                  = 5'h00, // Plain add
		add_with_carry_op       = 5'h01, // Add including carry
		op_sub                  = 5'h02, // Plain subtract
		sub_with_carry_op       = 5'h03, // Subtract including carry
		multiply_op             = 5'h04, // 16 x 16 multiply
		short_divide_op         = 5'h05, // 16 / 16 divide
		long_divide_op          = 5'h06, // 32 / 16 divide
		compare_decrement_op    = 5'h07, // Compare then step down
		compare_increment_op    = 5'h08, // Compare then step up
		normalize_count_op      = 5'h09, // Leading zero count
		arith_right_shift_op    = 5'h0a, // Sign filling shift
		op_logic_right_shift    = 5'h0b, // Zero filling shift
		move_sign_extend_op     = 5'h0c, // Byte to word, signed
		move_zero_extend_op     = 5'h0d, // Byte to word, unsigned
		bit_move_op             = 5'h0e, // Bit copy
		masked_field_op         = 5'h0f, // Masked byte update
		branch_test_clear_op    = 5'h10, // Branch if set, then clear
		branch_test_set_op      = 5'h11, // Branch if clear, then set
		push_and_call_op        = 5'h12, // Push register, then call
		context_switch_op       = 5'h13, // Push register, then load
		return_and_pop_op       = 5'h14, // Return, then pop register
		op_trap                 = 5'h15, // Software trap
		power_down_op           = 5'h16, // Power down request
		end_of_init_op          = 5'h17, // Initialization done
		segment_jump_op         = 5'h18, // Jump into code segment
		segment_override_seq_op = 5'h19, // Segment override sequence
		op_nop                  = 5'h1a  // Null operation
	} op_class_type;

	// ================================================================
	// Field positions and sizes
	// ================================================================
	localparam int          WORD_W      = 16;    // Data word width
	localparam int          SIGN_BIT    = 15;    // Word sign position
	localparam int          BYTE_SIGN   = 7;     // Byte sign position
	localparam int          TRAP_W      = 7;     // Trap number width
	localparam int          SEG_W       = 8;     // Code segment width
	localparam int          LEN_W       = 3;     // Length field width
	localparam logic [2:0]  LEN_SHORT   = 3'h2;  // Two byte encoding
	localparam logic [2:0]  LEN_LONG    = 3'h4;  // Four byte encoding
	localparam logic [15:0] STEP_ONE    = 16'h0001; // Small step
	localparam logic [15:0] STEP_TWO    = 16'h0002; // Large step
	localparam logic [1:0]  SEQ_ONE     = 2'h1;  // Override span base

endpackage : instr_class_pkg

// ==== instr_class_checks_properties.sv ====
`timescale 1ns/1ps
// ====
// Port checks for the instruction class executor
module instr_class_checks
	import instr_class_pkg::*;
(
	input wire logic         clock,              // System clock
	input wire logic         rst,                // Async reset
	input wire logic         op_valid,           // Operation present
	input wire op_class_type op_class,           // Operation class
	input wire logic         op_alt,             // Variant select
	input wire logic [15:0]  opnd_a,             // First operand
	input wire logic [15:0]  opnd_b,             // Second operand
	input wire logic         bit_in,             // Direct bit value
	input wire logic         nmi_level,          // Interrupt pin
	input wire logic [2:0]   length_r,           // Instr length
	input wire logic [15:0]  result_r,           // Main result
	input wire logic [15:0]  update_r,           // Register update
	input wire logic         update_we_r,        // Update valid
	input wire logic [31:0]  muldiv_pair_r,      // Muldiv pair out
	input wire logic         bit_out_r,          // Bit write value
	input wire logic         bit_we_r,           // Bit write valid
	input wire logic         branch_r,           // Branch taken
	input wire logic         push_r,             // Push strobe
	input wire logic         call_r,             // Call strobe
	input wire logic         trap_r,             // Trap strobe
	input wire logic [6:0]   trap_num_r,         // Trap number
	input wire logic         power_down_r,       // Power down level
	input wire logic         reset_output_pin_r  // Init done pin
);
	logic [3:0] shamt; // Shift count field
	logic [6:0] trap_in; // Trap number field
	assign shamt = opnd_b[3:0];
	assign trap_in = opnd_b[6:0];
	default clocking dc @(posedge clock);
	endclocking
	default disable iff (rst);
	property p_mul_unsigned;
		op_valid && op_class == multiply_op && op_alt |=> length_r == LEN_SHORT
			&& muldiv_pair_r == {16'h0000, $past(opnd_a)} * {16'h0000, $past(opnd_b)};
	endproperty
	a_mul_unsigned: assert property (p_mul_unsigned) else $error("multiply mismatch");
	property p_cmpd;
		op_valid && op_class == compare_decrement_op |=> update_we_r
			&& update_r == $past(opnd_a) - ($past(op_alt) ? STEP_TWO : STEP_ONE);
	endproperty
	a_cmpd: assert property (p_cmpd) else $error("decrement step wrong");
	property p_cmpi;
		op_valid && op_class == compare_increment_op |=> update_we_r
			&& update_r == $past(opnd_a) + ($past(op_alt) ? STEP_TWO : STEP_ONE);
	endproperty
	a_cmpi: assert property (p_cmpi) else $error("increment step wrong");
	property p_arith_right_shift_op;
		op_valid && op_class == arith_right_shift_op
			|=> result_r == 16'($signed($past(opnd_a)) >>> $past(shamt));
	endproperty
	a_arith_right_shift_op: assert property (p_arith_right_shift_op) else $error("sign shift wrong");
	property p_sext;
		op_valid && op_class == move_sign_extend_op
			|=> result_r == {{8{$past(opnd_a[7])}}, $past(opnd_a[7:0])};
	endproperty
	a_sext: assert property (p_sext) else $error("sign extension wrong");
	property p_zext;
		op_valid && op_class == move_zero_extend_op |=> result_r[15:8] == 8'h00;
	endproperty
	a_zext: assert property (p_zext) else $error("zero extension wrong");
	property p_test_clear;
		op_valid && op_class == branch_test_clear_op && bit_in
			|=> branch_r && bit_we_r && !bit_out_r ##1 !bit_we_r || $past(op_valid);
	endproperty
	a_test_clear: assert property (p_test_clear) else $error("test clear wrong");
	property p_test_set;
		op_valid && op_class == branch_test_set_op && !bit_in |=> branch_r && bit_we_r && bit_out_r;
	endproperty
	a_test_set: assert property (p_test_set) else $error("test set wrong");
	property p_push_and_call_op;
		op_valid && op_class == push_and_call_op |=> push_r && call_r && length_r == LEN_LONG;
	endproperty
	a_push_and_call_op: assert property (p_push_and_call_op) else $error("push and call wrong");
	property p_trap;
		op_valid && op_class == op_trap |=> trap_r && trap_num_r == $past(trap_in);
	endproperty
	a_trap: assert property (p_trap) else $error("trap number wrong");
	property p_power_down_op;
		op_valid && op_class == power_down_op && nmi_level |=> power_down_r == $past(power_down_r);
	endproperty
	a_power_down_op: assert property (p_power_down_op) else $error("power down not refused");
	property p_end_of_init_op;
		op_valid && op_class == end_of_init_op |=> reset_output_pin_r [*2];
	endproperty
	a_end_of_init_op: assert property (p_end_of_init_op) else $error("init pin not set");
endmodule : instr_class_checks

bind instr_class_exec instr_class_checks u_checks (.clock, .rst, .op_valid, .op_class, .op_alt,
	.opnd_a, .opnd_b, .bit_in, .nmi_level, .length_r, .result_r, .update_r, .update_we_r,
	.muldiv_pair_r, .bit_out_r, .bit_we_r, .branch_r, .push_r, .call_r, .trap_r, .trap_num_r,
	.power_down_r, .reset_output_pin_r);

// ==== reg_stack_model.sv ====
`timescale 1ns/1ps
// ====
// System stack seen by the register file side
module reg_stack_model
(
	input  wire logic       clock,   // System clock
	input  wire logic       rst,     // Async reset
	input  wire logic       push_r,  // Push strobe
	input  wire logic       pop_r,   // Pop strobe
	output logic      [3:0] depth_r  // Words held
);
	// Count words pushed and popped
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			depth_r <= 4'h0;
		else if (push_r && !pop_r)
			depth_r <= depth_r + 4'h1;
		else if (pop_r && !push_r && depth_r != 4'h0)
			depth_r <= depth_r - 4'h1;
	end
endmodule : reg_stack_model

// ==== tb_cpu_instruction_class_decoder.sv ====
`timescale 1ns/1ps
// ====
// Self-checking bench for the instruction class executor
module tb_cpu_instruction_class_decoder
	import instr_class_pkg::*;
;
	typedef struct {
		op_class_type cls; // Class
		logic [3:0]   flg; // Alt, long, carry, bit
		logic [15:0]  a;   // First operand
		logic [15:0]  b;   // Second operand
		logic [31:0]  md;  // Muldiv pair in
		int           sel; // Output compared
		logic [31:0]  exp; // Expected value
		logic [2:0]   len; // Expected length
	} row_type;
	logic clock, rst, op_valid, op_alt, op_long, op_byte, carry_in, bit_in, nmi_level;
	op_class_type op_class;
	logic [15:0] opnd_a, opnd_b, result_r, update_r;
	logic [31:0] muldiv_pair_in, muldiv_pair_r;
	logic done_r, update_we_r, muldiv_we_r, carry_r, zero_r, div_err_r, bit_out_r, bit_we_r;
	logic branch_r, push_r, pop_r, call_r, trap_r, power_down_r, reset_output_pin_r;
	logic seg_we_r, seq_reg_r;
	logic [2:0] length_r;
	logic [6:0] trap_num_r;
	logic [7:0] seg_r;
	logic [1:0] seq_span_r;
	logic [3:0] depth_r;
	int n_errors = 0;
	int n_compared = 0;
	row_type rows[$];
	instr_class_exec u_dut (.clock, .rst, .op_valid, .op_class, .op_alt, .op_long, .op_byte,
		.opnd_a, .opnd_b, .muldiv_pair_in, .carry_in, .bit_in, .nmi_level, .done_r, .length_r,
		.result_r, .update_r, .update_we_r, .muldiv_pair_r, .muldiv_we_r, .carry_r, .zero_r,
		.div_err_r, .bit_out_r, .bit_we_r, .branch_r, .push_r, .pop_r, .call_r, .trap_r,
		.trap_num_r, .power_down_r, .reset_output_pin_r, .seg_r, .seg_we_r, .seq_span_r,
		.seq_reg_r);
	reg_stack_model u_stack (.clock, .rst, .push_r, .pop_r, .depth_r);
	initial clock = 1'b0;
	always #12.5 clock = ~clock;
	// ====
	// Shared tasks
	task automatic r(input op_class_type c, input logic [3:0] f, input logic [15:0] a, b,
		input logic [31:0] md, input int sel, input logic [31:0] exp, input logic [2:0] len);
		rows.push_back('{c, f, a, b, md, sel, exp, len});
	endtask : r
	// Present one op at a falling edge, leave it valid for one edge
	task automatic issue(input op_class_type c, input logic [3:0] f, input logic [15:0] a, b);
		op_valid = 1'b1;
		op_class = c;
		{op_alt, op_long, carry_in, bit_in} = f;
		opnd_a = a;
		opnd_b = b;
		@(negedge clock);
	endtask : issue
	task automatic idle();
		op_valid = 1'b0;
		@(negedge clock);
	endtask : idle
	task automatic chk(input logic [31:0] got, exp, input string msg);
		n_compared++;
		if (got !== exp)
		begin
			n_errors++;
			$display("FAIL %0t %s", $time, msg);
		end
	endtask : chk
	function automatic logic [31:0] pick(input int sel);
		case (sel)
			0: return {16'h0000, result_r};
			1: return {16'h0000, update_r};
			2: return muldiv_pair_r;
			3: return {24'h000000, seg_r};
			4: return {25'h0000000, trap_num_r};
			5: return {31'h00000000, bit_out_r};
			7: return {28'h0000000, carry_r, zero_r, muldiv_we_r, seg_we_r};
			default: return {29'h00000000, seq_reg_r, seq_span_r};
		endcase
	endfunction : pick
	task automatic conclude();
		$display("Compared %0d, mismatches %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : conclude
	// ====
	// Main sequence
	initial
	begin
		{op_valid, op_alt, op_long, op_byte, carry_in, bit_in, nmi_level} = 7'h00;
		op_class = op_nop;
		{opnd_a, opnd_b, muldiv_pair_in} = 64'h0;
		rst = 1'b1;
		repeat (5) @(negedge clock);
		rst = 1'b0;
		chk(reset_output_pin_r, 1'b0, "pin after reset");
		r(multiply_op, 4'h0, 16'hfffe, 16'h0003, 32'h0, 2, 32'hfffffffa, 3'h2);
		r(multiply_op, 4'h8, 16'hfffe, 16'h0003, 32'h0, 2, 32'h0002fffa, 3'h2);
		r(short_divide_op, 4'h8, 16'h0, 16'h0007, 32'habcd0064, 2, 32'h0002000e, 3'h2);
		r(short_divide_op, 4'h0, 16'h0, 16'h0002, 32'h1234fff9, 2, 32'hfffffffd, 3'h2);
		r(long_divide_op, 4'h8, 16'h0, 16'h0002, 32'h00010000, 2, 32'h00008000, 3'h2);
		r(long_divide_op, 4'h0, 16'h0, 16'h0007, 32'hffffff9c, 2, 32'hfffefff2, 3'h2);
		r(add_with_carry_op, 4'h6, 16'h0001, 16'h0002, 32'h0, 0, 32'h4, 3'h4);
		r(sub_with_carry_op, 4'h2, 16'h0005, 16'h0002, 32'h0, 0, 32'h2, 3'h2);
		r(compare_decrement_op, 4'h4, 16'h0010, 16'h0, 32'h0, 1, 32'h000f, 3'h4);
		r(compare_decrement_op, 4'h8, 16'h0000, 16'h0, 32'h0, 1, 32'hfffe, 3'h2);
		r(compare_increment_op, 4'h0, 16'hffff, 16'h0, 32'h0, 1, 32'h0000, 3'h2);
		r(compare_increment_op, 4'hc, 16'h0010, 16'h0, 32'h0, 1, 32'h0012, 3'h4);
		r(normalize_count_op, 4'h0, 16'h0001, 16'h0, 32'h0, 0, 32'h000f, 3'h2);
		r(normalize_count_op, 4'h0, 16'h8000, 16'h0, 32'h0, 0, 32'h0000, 3'h2);
		r(arith_right_shift_op, 4'h0, 16'h8000, 16'h4, 32'h0, 0, 32'hf800, 3'h2);
		r(arith_right_shift_op, 4'h0, 16'h4000, 16'h1, 32'h0, 0, 32'h2000, 3'h2);
		r(op_logic_right_shift, 4'h0, 16'h8000, 16'h4, 32'h0, 0, 32'h0800, 3'h2);
		r(move_sign_extend_op, 4'h4, 16'h0080, 16'h0080, 32'h0, 0, 32'hff80, 3'h4);
		r(move_sign_extend_op, 4'h0, 16'h007f, 16'h007f, 32'h0, 0, 32'h007f, 3'h2);
		r(move_zero_extend_op, 4'h0, 16'hff80, 16'hff80, 32'h0, 0, 32'h0080, 3'h2);
		r(bit_move_op, 4'h1, 16'h0, 16'h0, 32'h0, 5, 32'h1, 3'h4);
		r(bit_move_op, 4'h9, 16'h0, 16'h0, 32'h0, 5, 32'h0, 3'h4);
		r(masked_field_op, 4'h0, 16'h00aa, 16'h050f, 32'h0, 0, 32'h00a5, 3'h4);
		r(masked_field_op, 4'h8, 16'haa00, 16'h50f0, 32'h0, 0, 32'h5a00, 3'h4);
		r(context_switch_op, 4'h0, 16'h1234, 16'h5678, 32'h0, 1, 32'h5678, 3'h4);
		r(op_trap, 4'h0, 16'h0, 16'h0045, 32'h0, 4, 32'h45, 3'h2);
		r(segment_jump_op, 4'h0, 16'h0023, 16'h0, 32'h0, 3, 32'h23, 3'h4);
		r(segment_override_seq_op, 4'h0, 16'h0011, 16'h2, 32'h0, 6, 32'h3, 3'h2);
		r(segment_override_seq_op, 4'h4, 16'h0011, 16'h0, 32'h0, 6, 32'h1, 3'h4);
		r(sub_with_carry_op, 4'h2, 16'h0000, 16'h0000, 32'h0, 7, 32'h8, 3'h2);
		r(multiply_op, 4'h0, 16'h0000, 16'h0005, 32'h0, 7, 32'h6, 3'h2);
		r(segment_jump_op, 4'h0, 16'h0023, 16'h0, 32'h0, 7, 32'h5, 3'h4);
		r(segment_override_seq_op, 4'h8, 16'h0011, 16'h1, 32'h0, 6, 32'h6, 3'h2);
		foreach (rows[i])
		begin
			muldiv_pair_in = rows[i].md;
			issue(rows[i].cls, rows[i].flg, rows[i].a, rows[i].b);
			chk(pick(rows[i].sel), rows[i].exp, "row value");
			chk(length_r, rows[i].len, "row length");
			idle();
		end
		$display("Table rows done");
		nmi_level = 1'b1;
		issue(power_down_op, 4'h4, 16'h0, 16'h0);
		chk(power_down_r, 1'b0, "power down with pin high");
		chk(done_r, 1'b1, "refused op not done");
		nmi_level = 1'b0;
		issue(power_down_op, 4'h4, 16'h0, 16'h0);
		chk(power_down_r, 1'b1, "power down refused");
		issue(end_of_init_op, 4'h4, 16'h0, 16'h0);
		chk(reset_output_pin_r, 1'b1, "init pin");
		idle();
		chk(reset_output_pin_r, 1'b1, "init pin not held");
		$display("Power and init done");
		issue(compare_increment_op, 4'h0, 16'h0010, 16'h0);
		chk(update_r, 16'h0011, "first increment");
		issue(compare_increment_op, 4'h8, 16'h0020, 16'h0);
		chk(update_r, 16'h0022, "second increment");
		op_byte = 1'b1;
		issue(add_with_carry_op, 4'h0, 16'h00ff, 16'h0001);
		chk({carry_r, result_r[7:0]}, 9'h100, "byte carry");
		op_byte = 1'b0;
		issue(branch_test_clear_op, 4'h1, 16'h0, 16'h0);
		chk({branch_r, bit_we_r, bit_out_r}, 3'h6, "test clear taken");
		issue(branch_test_clear_op, 4'h0, 16'h0, 16'h0);
		chk({branch_r, bit_we_r}, 2'h0, "test clear idle");
		issue(branch_test_set_op, 4'h0, 16'h0, 16'h0);
		chk({branch_r, bit_we_r, bit_out_r}, 3'h7, "test set taken");
		issue(short_divide_op, 4'h0, 16'h0, 16'h0);
		chk(div_err_r, 1'b1, "divide by zero");
		idle();
		$display("Back to back done");
		issue(push_and_call_op, 4'h4, 16'h1234, 16'h4000);
		chk({push_r, call_r}, 2'h3, "push and call");
		issue(context_switch_op, 4'h4, 16'h0001, 16'h0002);
		chk(push_r, 1'b1, "switch push");
		issue(return_and_pop_op, 4'h0, 16'h0, 16'h0);
		chk({pop_r, length_r}, 4'ha, "return and pop");
		idle();
		chk(depth_r, 4'h2, "stack depth");
		$display("Stack done");
		rst = 1'b1;
		@(negedge clock);
		chk({reset_output_pin_r, power_down_r}, 2'h0, "mid reset");
		rst = 1'b0;
		idle();
		$display("Reset done");
		conclude();
	end
	// Cut a hang short
	initial
	begin
		repeat (3000) @(posedge clock);
		n_errors++;
		$display("FAIL %0t watchdog expired", $time);
		conclude();
	end
endmodule : tb_cpu_instruction_class_decoder
